/* File: core/spdlc_top.sv */
// Power-down, PLL-lock and strap control of the LVDS serializer, with AXI4-Lite registers
//
// Summary of operation
// - Range strap selects parallel clock band.
// - Modulation strap: off, small, large, reserved.
// - Power-down halts PLL, termination, output high-Z.
// - Release starts PLL lock, reconnects termination.
// - Output undriven until lock reported.
// - While locking, hold differential output zero.
// - Lock after exactly 16385 cycles from release.
// - Missing input supply forces power-down, ignores inputs.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module spdlc_top
   import spdlc_pkg::*;
#(
   parameter int LOCK_CYCLES = SPDLC_PLL_LOCK_CYCLES
) (
   // Clock and reset
   input  wire  logic                    aclk,
   input  wire  logic                    aresetn,
   // AXI4-Lite write address
   input  wire  logic [3:0]              s_axi_awaddr,
   input  wire  logic                    s_axi_awvalid,
   output       logic                    s_axi_awready,
   // AXI4-Lite write data
   input  wire  logic [31:0]             s_axi_wdata,
   input  wire  logic [3:0]              s_axi_wstrb,
   input  wire  logic                    s_axi_wvalid,
   output       logic                    s_axi_wready,
   // AXI4-Lite write response
   output       logic [1:0]              s_axi_bresp,
   output       logic                    s_axi_bvalid,
   input  wire  logic                    s_axi_bready,
   // AXI4-Lite read address
   input  wire  logic [3:0]              s_axi_araddr,
   input  wire  logic                    s_axi_arvalid,
   output       logic                    s_axi_arready,
   // AXI4-Lite read data
   output       logic [31:0]             s_axi_rdata,
   output       logic [1:0]              s_axi_rresp,
   output       logic                    s_axi_rvalid,
   input  wire  logic                    s_axi_rready,
   // Device pins
   input  wire  logic                    power_down_n,
   input  wire  logic                    input_buffer_supply,
   input  wire  logic                    freq_range_sel_hi,
   input  wire  logic                    freq_range_sel_lo,
   input  wire  logic                    phase_mod_sel_hi,
   input  wire  logic                    phase_mod_sel_lo,
   // PLL and output stage controls
   output       spdlc_pkg::spdlc_link_ctrl_t link_ctrl
);
   import spdlc_pkg::*;

   localparam int CW = $clog2(LOCK_CYCLES + 1);
   localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CYCLES);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic             aw_held;
      logic [3:0]       aw_addr;
      logic             w_held;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic             force_pd;
      logic [CW-1:0]    count;
      logic             supply_ok;
      spdlc_link_ctrl_t link;
   } spdlc_state_t;

   spdlc_state_t state;
   spdlc_state_t next_state;

   always_comb begin
      logic       pd_req;
      logic       wr_go;
      logic [3:0] rd_addr;
      next_state = state;
      pd_req     = 1'b0;
      wr_go      = 1'b0;
      rd_addr    = s_axi_araddr;

      // -----------------------------------------------------------------
      // Power-down, straps and lock counter
      // -----------------------------------------------------------------
      next_state.supply_ok = input_buffer_supply;
      // Supply loss overrides the pin, so a floating pin cannot wake the core
      pd_req = !input_buffer_supply || !power_down_n || state.force_pd;

      // Straps follow the pins only while their buffers are powered
      if (input_buffer_supply) begin
         next_state.link.pll_range = spdlc_range_t'({freq_range_sel_hi, freq_range_sel_lo});
         next_state.link.phase_mod = spdlc_mod_t'({phase_mod_sel_hi, phase_mod_sel_lo});
      end
      // Reserved modulation code leaves edges unshifted
      if (next_state.link.phase_mod == SPDLC_MOD_RSVD) begin
         next_state.link.phase_mod = SPDLC_MOD_OFF;
      end

      if (pd_req) begin
         next_state.count       = '0;
         next_state.link.locked = 1'b0;
      end else if (!state.link.locked) begin
         next_state.count = state.count + CW'(1);
         if (next_state.count == LOCK_LAST) begin
            next_state.link.locked = 1'b1;
         end
      end

      next_state.link.pll_enable    = !pd_req;
      next_state.link.term_connect  = !pd_req;
      next_state.link.out_hiz       = pd_req;
      next_state.link.out_drive     = !pd_req && next_state.link.locked;
      next_state.link.out_hold_zero = !pd_req && !next_state.link.locked;

      // -----------------------------------------------------------------
      // AXI4-Lite write
      // -----------------------------------------------------------------
      if (s_axi_awvalid && state.awready) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state.wready) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      wr_go = state.aw_held && state.w_held && !state.bvalid;
      if (wr_go) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = SPDLC_RESP_OKAY;
         unique case (state.aw_addr)
            SPDLC_OFS_CTRL: begin
               if (state.w_strb[0]) begin
                  next_state.force_pd = state.w_data[SPDLC_CTRL_FORCE_PD_BIT];
               end
            end
            SPDLC_OFS_STATUS, SPDLC_OFS_COUNT, SPDLC_OFS_STRAP: begin
               // Read-only; writes are accepted and dropped
            end
            default: begin
               next_state.bresp = SPDLC_RESP_SLVERR;
            end
         endcase
      end
      next_state.awready = !next_state.aw_held && !next_state.bvalid;
      next_state.wready  = !next_state.w_held && !next_state.bvalid;

      // -----------------------------------------------------------------
      // AXI4-Lite read
      // -----------------------------------------------------------------
      if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state.arready) begin
         next_state.rvalid = 1'b1;
         next_state.rdata  = 32'h0000_0000;
         next_state.rresp  = SPDLC_RESP_OKAY;
         unique case (rd_addr)
            SPDLC_OFS_CTRL: begin
               next_state.rdata[SPDLC_CTRL_FORCE_PD_BIT] = state.force_pd;
            end
            SPDLC_OFS_STATUS: begin
               next_state.rdata[SPDLC_STAT_LOCKED_BIT] = state.link.locked;
               next_state.rdata[SPDLC_STAT_PD_BIT]     = state.link.out_hiz;
               next_state.rdata[SPDLC_STAT_SUPPLY_BIT] = state.supply_ok;
               next_state.rdata[SPDLC_STAT_MOD_RSVD_BIT] =
                  ({phase_mod_sel_hi, phase_mod_sel_lo} == SPDLC_MOD_RSVD) && state.supply_ok;
            end
            SPDLC_OFS_COUNT: begin
               next_state.rdata[CW-1:0] = state.count;
            end
            SPDLC_OFS_STRAP: begin
               next_state.rdata[SPDLC_STRAP_RANGE_LSB +: 2] = state.link.pll_range;
               next_state.rdata[SPDLC_STRAP_MOD_LSB +: 2]   = state.link.phase_mod;
            end
            default: begin
               next_state.rresp = SPDLC_RESP_SLVERR;
            end
         endcase
      end
      next_state.arready = !next_state.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state                    <= '0;
         state.force_pd           <= SPDLC_CTRL_FORCE_PD_RST;
         state.link.out_hiz       <= 1'b1;
         state.link.pll_range     <= SPDLC_RANGE_3_5;
         state.link.phase_mod     <= SPDLC_MOD_OFF;
      end else begin
         state <= next_state;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign s_axi_awready = state.awready;
   assign s_axi_wready  = state.wready;
   assign s_axi_bvalid  = state.bvalid;
   assign s_axi_bresp   = state.bresp;
   assign s_axi_arready = state.arready;
   assign s_axi_rvalid  = state.rvalid;
   assign s_axi_rdata   = state.rdata;
   assign s_axi_rresp   = state.rresp;
   assign link_ctrl     = state.link;

endmodule : spdlc_top

/* File: inc/spdlc_pkg.sv */
// Package of constants and types for the serializer power-down and lock control
package spdlc_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [3:0]  SPDLC_OFS_CTRL   = 4'h0;
   localparam logic [3:0]  SPDLC_OFS_STATUS = 4'h4;
   localparam logic [3:0]  SPDLC_OFS_COUNT  = 4'h8;
   localparam logic [3:0]  SPDLC_OFS_STRAP  = 4'hC;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int          SPDLC_CTRL_FORCE_PD_BIT  = 0;
   localparam int          SPDLC_STAT_LOCKED_BIT    = 0;
   localparam int          SPDLC_STAT_PD_BIT        = 1;
   localparam int          SPDLC_STAT_SUPPLY_BIT    = 2;
   localparam int          SPDLC_STAT_MOD_RSVD_BIT  = 3;
   localparam int          SPDLC_STRAP_RANGE_LSB    = 0;
   localparam int          SPDLC_STRAP_MOD_LSB      = 2;

   // -----------------------------------------------------------------
   // Reset values and timing
   // -----------------------------------------------------------------
   localparam logic        SPDLC_CTRL_FORCE_PD_RST  = 1'b0;
   localparam int          SPDLC_PLL_LOCK_CYCLES    = 16385;

   // AXI responses
   localparam logic [1:0]  SPDLC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  SPDLC_RESP_SLVERR = 2'h2;

   // -----------------------------------------------------------------
   // Strap decodes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPDLC_RANGE_3_5   = 2'h0,
      SPDLC_RANGE_5_10  = 2'h1,
      SPDLC_RANGE_10_20 = 2'h2,
      SPDLC_RANGE_20_35 = 2'h3
   } spdlc_range_t;

   typedef enum logic [1:0] {
      SPDLC_MOD_OFF   = 2'h0,
      SPDLC_MOD_SMALL = 2'h1,
      SPDLC_MOD_LARGE = 2'h2,
      SPDLC_MOD_RSVD  = 2'h3
   } spdlc_mod_t;

   // Controls toward the PLL and the LVDS output stage
   typedef struct packed {
      logic         pll_enable;
      logic         term_connect;
      logic         out_hiz;
      logic         out_hold_zero;
      logic         out_drive;
      logic         locked;
      spdlc_range_t pll_range;
      spdlc_mod_t   phase_mod;
   } spdlc_link_ctrl_t;

endpackage : spdlc_pkg

/* File: verification/spdlc_checker.sv */
// Checker for power-down, lock timing and strap decode
`timescale 1ns/10ps
module spdlc_checker
   import spdlc_pkg::*;
#(
   parameter int LOCK_CYCLES = SPDLC_PLL_LOCK_CYCLES
) (
   // Clock and reset
   input wire logic                        aclk,
   input wire logic                        aresetn,
   // Pins and link controls
   input wire logic                        power_down_n,
   input wire logic                        input_buffer_supply,
   input wire logic                        freq_range_sel_hi,
   input wire logic                        freq_range_sel_lo,
   input wire logic                        phase_mod_sel_hi,
   input wire logic                        phase_mod_sel_lo,
   input wire spdlc_pkg::spdlc_link_ctrl_t link_ctrl
);
   int         cnt;
   logic [1:0] mod_in;
   assign mod_in = {phase_mod_sel_hi, phase_mod_sel_lo};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Edges spent with the PLL enabled, timed apart from the design's own counter
   always_ff @(posedge aclk) begin
      if (!aresetn) cnt <= 0;
      else cnt <= link_ctrl.pll_enable ? cnt + 1 : 0;
   end
   a_pd_hiz: assert property (!power_down_n |=> link_ctrl.out_hiz && !link_ctrl.term_connect
      && !link_ctrl.pll_enable) else $error("power-down not honoured");
   a_pd_clear: assert property (!power_down_n |=> !link_ctrl.locked)
      else $error("lock kept in power-down");
   a_no_supply: assert property (!input_buffer_supply |=> link_ctrl.out_hiz)
      else $error("missing supply not forced down");
   a_release_term: assert property ($rose(link_ctrl.pll_enable) |-> link_ctrl.term_connect
      && !link_ctrl.out_hiz && !link_ctrl.locked && $past(power_down_n)
      && $past(input_buffer_supply)) else $error("release without termination");
   a_undriven: assert property (!link_ctrl.pll_enable || cnt < LOCK_CYCLES - 1
      |-> !link_ctrl.out_drive) else $error("driven before lock");
   a_drive_lock: assert property (link_ctrl.pll_enable && cnt >= LOCK_CYCLES - 1
      |-> link_ctrl.out_drive && !link_ctrl.out_hold_zero) else $error("not driven after lock");
   a_hold_zero: assert property (link_ctrl.pll_enable && cnt < LOCK_CYCLES - 1
      |-> link_ctrl.out_hold_zero && !link_ctrl.out_hiz) else $error("output not held at zero");
   a_strap_freeze: assert property (!input_buffer_supply |=> $stable(link_ctrl.pll_range)
      && $stable(link_ctrl.phase_mod)) else $error("straps followed unpowered pins");
   a_lock_time: assert property (link_ctrl.pll_enable
      |-> link_ctrl.locked == (cnt >= LOCK_CYCLES - 1)) else $error("lock time wrong");
   a_range_map: assert property (input_buffer_supply |=> link_ctrl.pll_range
      == $past({freq_range_sel_hi, freq_range_sel_lo})) else $error("range decode wrong");
   a_mod_map: assert property (input_buffer_supply |=> link_ctrl.phase_mod
      == ($past(mod_in) == 2'h3 ? 2'h0 : $past(mod_in))) else $error("mod decode wrong");
   cover property ($rose(link_ctrl.locked));
   cover property (!power_down_n && link_ctrl.pll_enable);
   cover property (input_buffer_supply && mod_in == 2'h3);
   cover property (!input_buffer_supply && link_ctrl.out_hiz);
endmodule : spdlc_checker

bind spdlc_top spdlc_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.aclk, .aresetn,
   .power_down_n, .input_buffer_supply, .freq_range_sel_hi, .freq_range_sel_lo,
   .phase_mod_sel_hi, .phase_mod_sel_lo, .link_ctrl);

/* File: verification/spdlc_deser_model.sv */
// Receiving deserializer stand-in
`timescale 1ns/10ps
module spdlc_deser_model
   import spdlc_pkg::*;
(
   // Clock and serializer output stage
   input wire logic                        aclk,
   input wire spdlc_pkg::spdlc_link_ctrl_t link_ctrl,
   // Receiver status
   output     logic                        rx_locked
);
   // Zero differential or high impedance carries no data, so only a driven line locks
   always_ff @(posedge aclk) rx_locked <= link_ctrl.out_drive && !link_ctrl.out_hiz;
endmodule : spdlc_deser_model

/* File: verification/tb.sv */
// Bench for power-down, lock and strap control over AXI4-Lite
`timescale 1ns/10ps
module tb;
   import spdlc_pkg::*;
   localparam int    LC = 5;
   logic             aclk = 1'b0, aresetn = 1'b0, pd_n = 1'b0, sup = 1'b1;
   logic [3:0]       straps = 4'h0, s0, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0]      wdata = 32'h0, rdata;
   logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic             awready, wready, bvalid, arready, rvalid, rx_locked;
   logic [1:0]       bresp, rresp;
   spdlc_link_ctrl_t link_ctrl;
   logic [33:0]      exp_q[$];
   int               n_errors = 0, total_checks = 0, n_lock;

   // Steady clock through every lock interval
   always #4 aclk = ~aclk;

   spdlc_top #(.LOCK_CYCLES(LC)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .power_down_n(pd_n), .input_buffer_supply(sup),
      .freq_range_sel_hi(straps[3]), .freq_range_sel_lo(straps[2]),
      .phase_mod_sel_hi(straps[1]), .phase_mod_sel_lo(straps[0]), .link_ctrl(link_ctrl));
   spdlc_deser_model far (.aclk(aclk), .link_ctrl(link_ctrl), .rx_locked(rx_locked));

   task test_done;
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   task cmp(input logic [33:0] got, input logic [33:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task cmp_link(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t link got %b expected %b", $time, got, exp);
      end
   endtask : cmp_link

   task guard(input int i);
      if (i > 999) begin
         n_errors++;
         $display("MISMATCH %0t wait timed out", $time);
         test_done;
      end
   endtask : guard

   // Each channel is held until its own handshake; readiness is read at the falling edge
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [33:0] e);
      logic ta, tw, tr, tk, tq;
      exp_q.push_back(e);
      @(posedge aclk);
      {awaddr, araddr, wdata, wstrb} <= {a, a, d, s};
      {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
      for (int i = 0; 1; i++) begin
         @(negedge aclk);
         guard(i);
         if (!(awvalid | wvalid | bready | arvalid | rready)) break;
         {ta, tw, tr} = {awvalid & awready, wvalid & wready, arvalid & arready};
         {tk, tq} = {bready & bvalid, rready & rvalid};
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         if (tk) bready <= 1'b0;
         if (tq) rready <= 1'b0;
      end
      @(posedge aclk);
   endtask : xfer

   task rd(input logic [3:0] a, input logic [33:0] e);
      xfer(1'b0, a, 32'h0, 4'hF, e);
   endtask : rd

   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      xfer(1'b1, a, d, s, {r, 32'h0});
   endtask : wr

   // Oldest note is matched against each completed response
   always @(negedge aclk) begin
      if (bvalid && bready) cmp({bresp, 32'h0}, exp_q.pop_front());
      if (rvalid && rready) cmp({rresp, rdata}, exp_q.pop_front());
   end

   initial begin
      void'($urandom(74815));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(SPDLC_OFS_CTRL, 34'h0);
      for (int k = 0; k < 16; k++) begin
         straps <= k[3:0];
         rd(SPDLC_OFS_STRAP, {30'h0, (k[1:0] == 2'h3) ? 2'h0 : k[1:0], k[3:2]});
         rd(SPDLC_OFS_STATUS, {30'h0, k[1:0] == 2'h3, 3'b110});
      end
      // Small amplitude only, so any range may be drawn while the PLL runs
      straps <= {2'($urandom), 2'h1};
      pd_n <= 1'b1;
      repeat (2) @(posedge aclk);
      pd_n <= 1'b0;
      @(posedge aclk);
      rd(SPDLC_OFS_COUNT, 34'h0);
      cmp_link(rx_locked, 1'b0);
      pd_n <= 1'b1;
      // One falling edge passes before the release edge, hence one wait more than the count
      for (n_lock = 0; link_ctrl.locked !== 1'b1; n_lock++) begin
         guard(n_lock);
         @(negedge aclk);
         if (link_ctrl.pll_enable && !link_ctrl.locked) begin
            cmp_link(link_ctrl.out_hold_zero, 1'b1);
         end
      end
      cmp(34'(n_lock), 34'(LC + 1));
      rd(SPDLC_OFS_COUNT, 34'(LC));
      rd(SPDLC_OFS_STATUS, 34'h5);
      cmp_link(rx_locked, 1'b1);
      wr(SPDLC_OFS_CTRL, 32'h1, 4'h0, SPDLC_RESP_OKAY);
      rd(SPDLC_OFS_STATUS, 34'h5);
      wr(SPDLC_OFS_CTRL, $urandom | 32'h1, 4'hF, SPDLC_RESP_OKAY);
      rd(SPDLC_OFS_CTRL, 34'h1);
      rd(SPDLC_OFS_STATUS, 34'h6);
      wr(SPDLC_OFS_STATUS, $urandom, 4'hF, SPDLC_RESP_OKAY);
      wr(4'h2, $urandom, 4'hF, SPDLC_RESP_SLVERR);
      rd(4'h6, {SPDLC_RESP_SLVERR, 32'h0});
      wr(SPDLC_OFS_CTRL, 32'h0, 4'hF, SPDLC_RESP_OKAY);
      s0 = straps;
      sup <= 1'b0;
      straps <= ~s0;
      rd(SPDLC_OFS_STRAP, {30'h0, s0[1:0], s0[3:2]});
      rd(SPDLC_OFS_STATUS, 34'h2);
      test_done;
   end
endmodule : tb
